// [common/rdss_cfg.svh]
/*
 * constants for the regen duty supervisor and stop select block.
 * assumes a 20 MHz reference clock; included by bare name.
 */
`ifndef RDSS_CFG_SVH
`define RDSS_CFG_SVH

// ----------------------------------------
// duty supervision (duty in 0.1% units)
// ----------------------------------------
`define RDSS_DUTY_W 10
`define RDSS_FIXED_DUTY_PERMILLE 10'h01e
`define RDSS_ALARM_PCT 7'h55
`define RDSS_FULL_PCT 7'h64

// ----------------------------------------
// output terminal function codes
// ----------------------------------------
`define RDSS_TERM_ALARM_POS 8'h07
`define RDSS_TERM_ALARM_NEG 8'h6b

// ----------------------------------------
// stop method settings
// ----------------------------------------
`define RDSS_STOP_W 14
`define RDSS_STOP_COAST_MAX 14'h0064
`define RDSS_STOP_OFS_MIN 14'h03e8
`define RDSS_STOP_OFS_MAX 14'h044c
`define RDSS_STOP_DECEL_A 14'h270f
`define RDSS_STOP_DECEL_B 14'h22b8

// ----------------------------------------
// timing
// ----------------------------------------
`define RDSS_CLK_HZ 20000000
`define RDSS_SEC_W 7

`endif

// [common/rdss_pkg.sv]
/*
 * types shared by the regen duty supervisor and stop select block.
 * assumes the cfg header for widths.
 */
`default_nettype none
`include "rdss_cfg.svh"
package rdss_pkg;
	// stop sequencer states, gray along idle-run-delay-coast
	typedef enum logic [1:0] {
		RDSS_IDLE = 2'b00,
		RDSS_RUN = 2'b01,
		RDSS_DELAY = 2'b11,
		RDSS_COAST = 2'b10
	} rdss_state_t;
	// stop kind requested of the speed ramp
	typedef enum logic [1:0] {
		RDSS_STOP_NONE = 2'b00,
		RDSS_STOP_DECEL = 2'b01,
		RDSS_STOP_COAST = 2'b10
	} rdss_stop_t;
endpackage
`default_nettype wire

// [common/rdss_tick_if.sv]
/*
 * carrier for the seconds delay timer between top and counter.
 * assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface rdss_tick_if;
	logic start; // load and run the timer
	logic clear; // abandon the count
	logic [6:0] secs; // seconds to wait
	logic done; // level once the wait has elapsed
	modport ctl (output start, output clear, output secs, input done);
	modport tmr (input start, input clear, input secs, output done);
endinterface
`default_nettype wire

// [core/rdss_delay_timer.sv]
/*
 * seconds delay timer for the coasting stop.
 * assumes a 20 MHz clock; counts whole seconds, zero means at once.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rdss_cfg.svh"
module rdss_delay_timer (
	input wire logic clk_i,
	input wire logic arst_n_i,
	rdss_tick_if.tmr tick
);
	import rdss_pkg::*;
	// ----------------------------------------
	// prescaler and second counter
	// ----------------------------------------
	localparam int unsigned SEC_CYC = `RDSS_CLK_HZ; // cycles per second
	logic [24:0] pre_reg, pre_next; // cycle count within a second
	logic [6:0] sec_reg, sec_next; // seconds still to run
	logic act_reg, act_next; // timer running
	logic done_reg, done_next; // wait elapsed, held until a clear or a nonzero load

	// next value: a load restarts, a clear stops the count and drops done but keeps the seconds
	always_comb begin
		pre_next = pre_reg;
		sec_next = sec_reg;
		act_next = act_reg;
		done_next = done_reg;
		if (tick.clear) begin
			act_next = 1'b0;
			done_next = 1'b0;
			pre_next = '0;
		end else if (tick.start) begin
			pre_next = '0;
			sec_next = tick.secs;
			act_next = (tick.secs != '0);
			done_next = (tick.secs == '0);
		end else if (act_reg) begin
			if (pre_reg == 25'(SEC_CYC - 1)) begin
				pre_next = '0;
				sec_next = sec_reg - 7'h01;
				if (sec_reg == 7'h01) begin
					act_next = 1'b0;
					done_next = 1'b1;
				end
			end else begin
				pre_next = pre_reg + 25'h0000001;
			end
		end
	end

	// registers only
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_reg <= '0;
			sec_reg <= '0;
			act_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			sec_reg <= sec_next;
			act_reg <= act_next;
			done_reg <= done_next;
		end
	end

	assign tick.done = done_reg;
endmodule
`default_nettype wire

// [core/rdss_top.sv]
/*
 * regen duty supervision and stop method selection for a drive unit.
 * assumes pin inputs are asynchronous and parameter settings are
 * quasi-static values from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rdss_cfg.svh"
module rdss_top (
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	// settings (same domain)
	input wire logic REGEN_FUNCTION_SELECT_I, // 0 or 1
	input wire logic [4:0] REGEN_DUTY_LIMIT_I, // percent, 0..30
	input wire logic [`RDSS_DUTY_W-1:0] DUTY_MEASURED_I, // 0.1% units
	input wire logic [7:0] OUTPUT_TERMINAL_SELECT_A_I,
	input wire logic [7:0] OUTPUT_TERMINAL_SELECT_B_I,
	input wire logic [`RDSS_STOP_W-1:0] STOP_METHOD_SETTING_I,
	input wire logic PANEL_STOP_ACTIVE_I,
	input wire logic COMM_ERROR_STOP_ACTIVE_I,
	input wire logic JOG_ACTIVE_I,
	input wire logic PRE_EXCITING_I, // pre-excitation in progress
	// pins (asynchronous)
	input wire logic FORWARD_START_INPUT_I,
	input wire logic REVERSE_START_INPUT_I,
	input wire logic PRE_EXCITATION_INPUT_I,
	input wire logic DRIVE_ENABLE_INPUT_I,
	input wire logic OUTPUT_SHUTOFF_INPUT_I,
	// outputs
	output logic REGEN_DUTY_ALARM_O, // internal alarm level
	output logic REGEN_ALARM_PANEL_INDICATION_O,
	output logic REGEN_OVERVOLTAGE_FAULT_O,
	output logic TERMINAL_A_O,
	output logic TERMINAL_B_O,
	output logic RUN_COMMAND_O, // drive output allowed to switch
	output logic DIRECTION_REVERSE_O,
	output logic RUNNING_O,
	output rdss_pkg::rdss_stop_t STOP_KIND_O,
	output logic USE_STARTING_SPEED_O // restart from starting speed
);
	import rdss_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] pin_meta_reg; // first stage, read only by second
	logic [4:0] pin_sync_reg; // second stage, safe to use
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= {FORWARD_START_INPUT_I, REVERSE_START_INPUT_I,
				PRE_EXCITATION_INPUT_I, DRIVE_ENABLE_INPUT_I, OUTPUT_SHUTOFF_INPUT_I};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	logic fwd, rev, exc_pin, en_pin, shut_pin;
	assign {fwd, rev, exc_pin, en_pin, shut_pin} = pin_sync_reg;

	// ----------------------------------------
	// duty supervision
	// ----------------------------------------
	// threshold in 0.1% units: limit% * pct (a percentage of a percentage)
	function automatic logic [`RDSS_DUTY_W-1:0] thresh(input logic [9:0] lim_pm,
		input logic [6:0] pct);
		logic [16:0] prod;
		prod = 17'(lim_pm) * 17'(pct);
		thresh = `RDSS_DUTY_W'(prod / 17'd100);
	endfunction

	logic [9:0] eff_limit; // effective limit in 0.1% units
	always_comb begin
		if (!REGEN_FUNCTION_SELECT_I) begin
			eff_limit = `RDSS_FIXED_DUTY_PERMILLE;
		end else begin
			eff_limit = 10'(REGEN_DUTY_LIMIT_I) * 10'h00a;
		end
	end

	logic alarm_reg, alarm_next; // alarm level, releases below threshold
	logic panel_reg, panel_next;
	logic fault_reg, fault_next; // sticky until reset
	logic term_a_reg, term_a_next;
	logic term_b_reg, term_b_next;

	// terminal mapping by function code and polarity
	function automatic logic term_map(input logic [7:0] code, input logic al);
		if (code == `RDSS_TERM_ALARM_POS) begin
			term_map = al;
		end else if (code == `RDSS_TERM_ALARM_NEG) begin
			term_map = !al;
		end else begin
			term_map = 1'b0; // other functions live elsewhere
		end
	endfunction

	// next alarm and fault values
	always_comb begin
		alarm_next = (DUTY_MEASURED_I >= thresh(eff_limit, `RDSS_ALARM_PCT));
		panel_next = alarm_next && REGEN_FUNCTION_SELECT_I;
		// the fault latches; the alarm alone never feeds the trip path
		fault_next = fault_reg ||
			(DUTY_MEASURED_I >= thresh(eff_limit, `RDSS_FULL_PCT));
		term_a_next = term_map(OUTPUT_TERMINAL_SELECT_A_I, alarm_next);
		term_b_next = term_map(OUTPUT_TERMINAL_SELECT_B_I, alarm_next);
	end

	// alarm registers
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			alarm_reg <= 1'b0;
			panel_reg <= 1'b0;
			fault_reg <= 1'b0;
			term_a_reg <= 1'b0;
			term_b_reg <= 1'b0;
		end else begin
			alarm_reg <= alarm_next;
			panel_reg <= panel_next;
			fault_reg <= fault_next;
			term_a_reg <= term_a_next;
			term_b_reg <= term_b_next;
		end
	end

	// ----------------------------------------
	// start decoding
	// ----------------------------------------
	logic split_mode; // forward is start, reverse is direction
	logic coast_mode; // coasting stop configured
	logic [6:0] coast_secs; // delay before shutoff
	logic override; // panel stop, comm stop or jog
	logic start_cmd, rev_cmd, enabled;
	always_comb begin
		split_mode = 1'b0;
		coast_mode = 1'b0;
		coast_secs = '0;
		if (STOP_METHOD_SETTING_I <= `RDSS_STOP_COAST_MAX) begin
			coast_mode = 1'b1;
			coast_secs = 7'(STOP_METHOD_SETTING_I);
		end else if (STOP_METHOD_SETTING_I >= `RDSS_STOP_OFS_MIN &&
			STOP_METHOD_SETTING_I <= `RDSS_STOP_OFS_MAX) begin
			coast_mode = 1'b1;
			split_mode = 1'b1;
			coast_secs = 7'(STOP_METHOD_SETTING_I - `RDSS_STOP_OFS_MIN);
		end else if (STOP_METHOD_SETTING_I == `RDSS_STOP_DECEL_B) begin
			split_mode = 1'b1;
		end
		override = PANEL_STOP_ACTIVE_I || COMM_ERROR_STOP_ACTIVE_I ||
			JOG_ACTIVE_I;
		if (split_mode) begin
			start_cmd = fwd;
			rev_cmd = rev;
		end else begin
			start_cmd = fwd ^ rev; // both on acts as no start
			rev_cmd = rev && !fwd;
		end
		// either pin may withdraw the enable
		enabled = en_pin && !shut_pin;
	end

	// ----------------------------------------
	// stop sequencer
	// ----------------------------------------
	rdss_tick_if tick();
	rdss_delay_timer u_timer (
		.clk_i(REF_CLK_I),
		.arst_n_i(ARST_N_I),
		.tick(tick.tmr)
	);

	rdss_state_t state_reg, state_next;
	rdss_stop_t stop_reg, stop_next;
	logic dir_reg, dir_next;
	logic restart_reg, restart_next; // next start uses starting speed

	// next state and timer control
	always_comb begin
		state_next = state_reg;
		stop_next = stop_reg;
		dir_next = dir_reg;
		restart_next = restart_reg;
		tick.start = 1'b0;
		tick.clear = 1'b0;
		tick.secs = coast_secs;
		unique case (state_reg)
			RDSS_IDLE: begin
				stop_next = RDSS_STOP_NONE;
				if (start_cmd && enabled && !fault_reg) begin
					state_next = RDSS_RUN;
					dir_next = rev_cmd;
				end
			end
			RDSS_RUN: begin
				dir_next = start_cmd ? rev_cmd : dir_reg;
				if (!start_cmd) begin
					// pre-excitation stop decelerates whatever is set
					if (!coast_mode || override || (exc_pin && PRE_EXCITING_I)) begin
						stop_next = RDSS_STOP_DECEL;
						state_next = RDSS_IDLE;
					end else begin
						tick.start = 1'b1;
						state_next = RDSS_DELAY;
					end
				end
			end
			RDSS_DELAY: begin
				// speed still follows the command here
				stop_next = RDSS_STOP_NONE;
				if (start_cmd) begin
					tick.clear = 1'b1;
					state_next = RDSS_RUN;
				end else if (override || (exc_pin && PRE_EXCITING_I)) begin
					tick.clear = 1'b1;
					stop_next = RDSS_STOP_DECEL;
					state_next = RDSS_IDLE;
				end else if (tick.done) begin
					tick.clear = 1'b1;
					stop_next = RDSS_STOP_COAST;
					state_next = RDSS_COAST;
				end
			end
			RDSS_COAST: begin
				stop_next = RDSS_STOP_COAST;
				if (start_cmd && enabled && !fault_reg) begin
					restart_next = 1'b1;
					// a restart is no longer a coast; a stale kind would mislead the ramp
					stop_next = RDSS_STOP_NONE;
					state_next = RDSS_RUN;
					dir_next = rev_cmd;
				end
			end
		endcase
		// a lost enable or a fault drops to idle at once
		if (!enabled || fault_reg) begin
			state_next = RDSS_IDLE;
			tick.clear = 1'b1;
		end
		if (state_next == RDSS_IDLE) begin
			restart_next = 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_reg <= RDSS_IDLE;
			stop_reg <= RDSS_STOP_NONE;
			dir_reg <= 1'b0;
			restart_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			stop_reg <= stop_next;
			dir_reg <= dir_next;
			restart_reg <= restart_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign REGEN_DUTY_ALARM_O = alarm_reg;
	assign REGEN_ALARM_PANEL_INDICATION_O = panel_reg;
	assign REGEN_OVERVOLTAGE_FAULT_O = fault_reg;
	assign TERMINAL_A_O = term_a_reg;
	assign TERMINAL_B_O = term_b_reg;
	assign RUN_COMMAND_O = (state_reg == RDSS_RUN) || (state_reg == RDSS_DELAY);
	// running drops with the shutoff
	assign RUNNING_O = RUN_COMMAND_O;
	assign DIRECTION_REVERSE_O = dir_reg;
	assign STOP_KIND_O = stop_reg;
	assign USE_STARTING_SPEED_O = restart_reg;
endmodule
`default_nettype wire

// [tb/rdss_contacts.sv]
/* model of the external start, direction and enable contacts.
 * assumes the bench calls its tasks; levels change just after an edge. */
`timescale 1ns/1ps
`default_nettype none
module rdss_contacts (
	input wire logic clk_i,
	output logic fwd_o,
	output logic rev_o,
	output logic excite_o,
	output logic en_o,
	output logic shut_o
);
	// contacts rest open, drive enabled
	initial begin
		fwd_o = 1'b0;
		rev_o = 1'b0;
		excite_o = 1'b0;
		en_o = 1'b1;
		shut_o = 1'b0;
	end
	// start contacts
	task automatic press(input logic f, input logic r);
		@(posedge clk_i);
		fwd_o <= f;
		rev_o <= r;
	endtask
	// enable and shutoff contacts
	task automatic gate(input logic e, input logic s);
		@(posedge clk_i);
		en_o <= e;
		shut_o <= s;
	endtask
	// pre-excitation contact
	task automatic excite(input logic l);
		@(posedge clk_i);
		excite_o <= l;
	endtask
endmodule
`default_nettype wire

// [tb/rdss_top_properties.sv]
/* port checker for rdss_top.
 * assumes settings hold still while the measured duty moves. */
`timescale 1ns/1ps
`default_nettype none
`include "rdss_cfg.svh"
module rdss_top_checker
	import rdss_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	input wire logic REGEN_FUNCTION_SELECT_I,
	input wire logic [4:0] REGEN_DUTY_LIMIT_I,
	input wire logic [`RDSS_DUTY_W-1:0] DUTY_MEASURED_I,
	input wire logic [7:0] OUTPUT_TERMINAL_SELECT_A_I,
	input wire logic OUTPUT_SHUTOFF_INPUT_I,
	input wire logic REGEN_DUTY_ALARM_O,
	input wire logic REGEN_ALARM_PANEL_INDICATION_O,
	input wire logic REGEN_OVERVOLTAGE_FAULT_O,
	input wire logic TERMINAL_A_O,
	input wire logic RUN_COMMAND_O,
	input wire logic RUNNING_O,
	input wire rdss_pkg::rdss_stop_t STOP_KIND_O,
	input wire logic USE_STARTING_SPEED_O
);
	import rdss_pkg::*;
	// ----------------------------------------
	// thresholds in 0.1% units
	// ----------------------------------------
	logic [9:0] lim_pm; // full duty limit
	logic [9:0] alarm_pm; // 85% point, rounded down
	// wide product: 300 * 85 would wrap in ten bits
	always_comb begin
		lim_pm = REGEN_FUNCTION_SELECT_I ? 10'(REGEN_DUTY_LIMIT_I) * 10'h00a
			: `RDSS_FIXED_DUTY_PERMILLE;
		alarm_pm = 10'((16'(lim_pm) * 16'h0055) / 16'h0064);
	end
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_alarm_set; DUTY_MEASURED_I >= alarm_pm |=> REGEN_DUTY_ALARM_O; endproperty
	property p_alarm_clr; DUTY_MEASURED_I < alarm_pm |=> !REGEN_DUTY_ALARM_O; endproperty
	property p_fault; DUTY_MEASURED_I >= lim_pm |=> REGEN_OVERVOLTAGE_FAULT_O; endproperty
	property p_fault_hold; REGEN_OVERVOLTAGE_FAULT_O |=> REGEN_OVERVOLTAGE_FAULT_O; endproperty
	property p_panel; !REGEN_FUNCTION_SELECT_I |=> !REGEN_ALARM_PANEL_INDICATION_O; endproperty
	property p_term_neg;
		OUTPUT_TERMINAL_SELECT_A_I == `RDSS_TERM_ALARM_NEG |=> TERMINAL_A_O != REGEN_DUTY_ALARM_O;
	endproperty
	property p_term_off;
		OUTPUT_TERMINAL_SELECT_A_I != `RDSS_TERM_ALARM_POS
			&& OUTPUT_TERMINAL_SELECT_A_I != `RDSS_TERM_ALARM_NEG |=> !TERMINAL_A_O;
	endproperty
	// two sync flops plus the state edge, with one spare
	property p_shut; OUTPUT_SHUTOFF_INPUT_I [*4] |=> !RUN_COMMAND_O; endproperty
	property p_coast; STOP_KIND_O == RDSS_STOP_COAST |-> !RUNNING_O && !RUN_COMMAND_O; endproperty
	sequence s_coasting; STOP_KIND_O == RDSS_STOP_COAST && !RUN_COMMAND_O; endsequence
	sequence s_restart; s_coasting ##1 RUN_COMMAND_O; endsequence
	property p_restart; s_restart |-> USE_STARTING_SPEED_O; endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm missing");
	a_alarm_clr: assert property (p_alarm_clr) else $error("alarm stuck");
	a_fault: assert property (p_fault) else $error("fault missing");
	a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
	a_panel: assert property (p_panel) else $error("panel shown");
	a_term_neg: assert property (p_term_neg) else $error("terminal polarity");
	a_term_off: assert property (p_term_off) else $error("terminal unused high");
	a_shut: assert property (p_shut) else $error("shutoff ignored");
	a_coast: assert property (p_coast) else $error("running while coasting");
	a_restart: assert property (p_restart) else $error("no starting speed");
endmodule
bind rdss_top rdss_top_checker u_chk (.REF_CLK_I, .ARST_N_I, .REGEN_FUNCTION_SELECT_I,
	.REGEN_DUTY_LIMIT_I, .DUTY_MEASURED_I, .OUTPUT_TERMINAL_SELECT_A_I, .OUTPUT_SHUTOFF_INPUT_I,
	.REGEN_DUTY_ALARM_O, .REGEN_ALARM_PANEL_INDICATION_O, .REGEN_OVERVOLTAGE_FAULT_O,
	.TERMINAL_A_O, .RUN_COMMAND_O, .RUNNING_O, .STOP_KIND_O, .USE_STARTING_SPEED_O);
`default_nettype wire

// [tb/tb_top.sv]
/* self-checking bench for rdss_top.
 * assumes the contact model on the pins; resets between scenarios. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rdss_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic sel = 1'b0; // fixed 3% duty at start, so no early fault
	logic [4:0] lim = 5'h00;
	logic [9:0] duty = 10'h000;
	logic [7:0] term_a = 8'h07;
	logic [13:0] stop_set = 14'h270f;
	logic panel_stop = 1'b0;
	logic comm_stop = 1'b0;
	logic jog = 1'b0;
	logic pre_exc = 1'b0;
	logic fwd, rev, exc, en, shut;
	logic alarm, panel, fault, ta, tb, run, dir, running, use_ss;
	rdss_stop_t kind;
	int bad_count = 0;
	int check_count = 0;
	always #25 ref_clk = ~ref_clk;
	rdss_contacts pins (.clk_i(ref_clk), .fwd_o(fwd), .rev_o(rev), .excite_o(exc), .en_o(en),
		.shut_o(shut));
	rdss_top DUT (.REF_CLK_I(ref_clk), .ARST_N_I(arst_n), .REGEN_FUNCTION_SELECT_I(sel),
		.REGEN_DUTY_LIMIT_I(lim), .DUTY_MEASURED_I(duty), .OUTPUT_TERMINAL_SELECT_A_I(term_a),
		.OUTPUT_TERMINAL_SELECT_B_I(8'h6b), .STOP_METHOD_SETTING_I(stop_set),
		.PANEL_STOP_ACTIVE_I(panel_stop), .COMM_ERROR_STOP_ACTIVE_I(comm_stop),
		.JOG_ACTIVE_I(jog), .PRE_EXCITING_I(pre_exc), .FORWARD_START_INPUT_I(fwd),
		.REVERSE_START_INPUT_I(rev), .PRE_EXCITATION_INPUT_I(exc), .DRIVE_ENABLE_INPUT_I(en),
		.OUTPUT_SHUTOFF_INPUT_I(shut), .REGEN_DUTY_ALARM_O(alarm),
		.REGEN_ALARM_PANEL_INDICATION_O(panel), .REGEN_OVERVOLTAGE_FAULT_O(fault),
		.TERMINAL_A_O(ta), .TERMINAL_B_O(tb), .RUN_COMMAND_O(run), .DIRECTION_REVERSE_O(dir),
		.RUNNING_O(running), .STOP_KIND_O(kind), .USE_STARTING_SPEED_O(use_ss));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [1:0] seen, input logic [1:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// sample one step after the edge so its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_run(input logic v);
		for (int i = 0; i < 12 && run !== v; i++) cyc(1);
		chk("run command", run, v);
	endtask
	// polled every cycle, so a one-cycle decel pulse is not missed
	task automatic wait_kind(input rdss_stop_t k);
		for (int i = 0; i < 12 && kind !== k; i++) cyc(1);
		chk("stop kind", kind, k);
	endtask
	task automatic set_duty(input logic [9:0] d);
		@(posedge ref_clk);
		duty <= d;
		cyc(2);
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		arst_n <= 1'b0;
		duty <= 10'h000;
		pins.press(1'b0, 1'b0);
		cyc(2);
		@(posedge ref_clk);
		arst_n <= 1'b1;
		cyc(1);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_limit();
		@(posedge ref_clk);
		sel <= 1'b1;
		lim <= 5'h0a; // high-duty resistor setup
		pins.press(1'b1, 1'b0);
		wait_run(1'b1);
		set_duty(10'h054);
		chk("alarm", alarm, 1'b0);
		set_duty(10'h055);
		chk("alarm", alarm, 1'b1);
		chk("panel", panel, 1'b1);
		chk("terminal a", ta, 1'b1);
		chk("terminal b", tb, 1'b0);
		cyc(4);
		chk("run command", run, 1'b1);
		term_a <= 8'h6b; // negative polarity while the alarm releases
		set_duty(10'h054);
		chk("alarm", alarm, 1'b0);
		chk("terminal a", ta, 1'b1);
		term_a <= 8'h07;
		set_duty(10'h064);
		chk("fault", fault, 1'b1);
		wait_run(1'b0);
		do_reset();
		chk("fault", fault, 1'b0);
	endtask
	task automatic t_fixed();
		@(posedge ref_clk);
		lim <= 5'h06; // 6% resistor setup within its rating
		set_duty(10'h032);
		chk("alarm", alarm, 1'b0);
		set_duty(10'h033);
		chk("alarm", alarm, 1'b1);
		set_duty(10'h000);
		sel <= 1'b0;
		term_a <= 8'h08;
		set_duty(10'h019);
		chk("alarm", alarm, 1'b1);
		chk("fault", fault, 1'b0);
		chk("panel", panel, 1'b0);
		chk("terminal a", ta, 1'b0);
		set_duty(10'h01e);
		chk("fault", fault, 1'b1);
		term_a <= 8'h07;
		do_reset();
	endtask
	task automatic t_coast(input logic [13:0] s);
		@(posedge ref_clk);
		stop_set <= s; // zero second delay keeps the run short
		pins.press(1'b0, 1'b1);
		wait_run(1'b1);
		chk("direction", dir, 1'b1);
		pins.press(1'b0, 1'b0);
		wait_kind(RDSS_STOP_COAST);
		chk("running", running, 1'b0);
		pins.press(1'b1, 1'b0);
		wait_run(1'b1);
		chk("direction", dir, 1'b0);
		chk("starting speed", use_ss, 1'b1);
		chk("stop kind", kind, RDSS_STOP_NONE);
		do_reset();
	endtask
	task automatic t_split(input logic [13:0] s, input rdss_stop_t k);
		@(posedge ref_clk);
		stop_set <= s;
		pins.press(1'b1, 1'b1);
		wait_run(1'b1);
		chk("direction", dir, 1'b1);
		pins.press(1'b0, 1'b1);
		wait_kind(k);
		do_reset();
	endtask
	// each override, then pre-excitation, turns a coast into a decel
	task automatic t_override(input int m);
		@(posedge ref_clk);
		stop_set <= 14'h0000;
		panel_stop <= (m == 0);
		comm_stop <= (m == 1);
		jog <= (m == 2);
		pre_exc <= (m == 3);
		pins.excite(m == 3);
		pins.press(1'b1, 1'b0);
		wait_run(1'b1);
		pins.press(1'b0, 1'b0);
		wait_kind(RDSS_STOP_DECEL);
		cyc(1);
		chk("stop kind", kind, RDSS_STOP_NONE);
		{panel_stop, comm_stop, jog, pre_exc} <= 4'h0;
		pins.excite(1'b0);
		do_reset();
	endtask
	task automatic t_shut();
		@(posedge ref_clk);
		stop_set <= 14'h270f;
		pins.press(1'b1, 1'b0);
		wait_run(1'b1);
		pins.gate(1'b1, 1'b1);
		wait_run(1'b0);
		pins.gate(1'b1, 1'b0);
		wait_run(1'b1);
		pins.gate(1'b0, 1'b0);
		wait_run(1'b0);
		pins.gate(1'b1, 1'b0);
		wait_run(1'b1);
		pins.press(1'b0, 1'b0);
		wait_kind(RDSS_STOP_DECEL);
		do_reset();
	endtask
	// ----------------------------------------
	// verdict, watchdog and main sequence
	// ----------------------------------------
	task automatic print_verdict();
		$display("mismatches %0d checks %0d", bad_count, check_count);
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		cyc(1);
		t_limit();
		t_fixed();
		t_coast(14'h0000);
		t_split(14'h03e8, RDSS_STOP_COAST);
		t_split(14'h22b8, RDSS_STOP_DECEL);
		for (int m = 0; m < 4; m++) t_override(m);
		t_shut();
		print_verdict();
	end
endmodule
`default_nettype wire
